// File: logic/accel_ctrl.v
`timescale 1ns/1ps
`include "accel_ctrl_regs.vh"
// Contract
// R01: With link set and both detectors on, activity waits until inactivity seen.
// R02: Host should cycle standby then measure after clearing link, autosleep or sleep.
// R03: Link plus autosleep: inactivity detected puts device to sleep.
// R04: In autosleep, detected activity wakes device to normal data rate.
// R05: Autosleep bit has no effect while link is clear.
// R06: Measure bit 0 standby, 1 measurement; reset gives standby.
// R07: Sleep suppresses new-sample event, FIFO push, uses wakeup rate.
// R08: In sleep only activity detection runs.
// R09: During sleep output data still updates at wakeup rate.
// R10: Wakeup field 00/01/10/11 gives 8/4/2/1 Hz sleep rate.
// R11: Enable bit 1 lets event drive interrupt; 0 blocks it.
// R12: New-sample, watermark, overrun enables gate only the interrupt output.
// R13: Enable, routing, flags share one bit order D7 to D0.
// R14: Routing 0 to pin a, 1 to pin b; each pin ORs its events.
// R15: Flag bit 1 means event occurred, 0 means not.
// R16: New-sample, watermark, overrun flags set always; cleared by axis data read.
// R17: Other flags cleared by reading the flag register.
// R18: Serial-wire bit 1 selects three-wire, 0 four-wire.
// R19: Polarity bit 0 active high pins, 1 active low.
// R20: Fixed-scale on keeps 4 mg/LSB widening with range; off gives 10 bits.
// R21: Justify 1 left-justifies, 0 right-justifies with sign extension.
// R22: Range 00/01/10/11 selects 2/4/8/16 g.
// R23: Below 16 g output is clipped, never rolls over.
// R24: Pin level is OR of enabled routed flags, with selected polarity.
module accel_ctrl #(
   parameter CLK_HZ = `CLK_HZ
) (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire [9:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [9:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [7:0] event_pulse,
   input wire [15:0] raw_sample,
   input wire odr_tick,
   output reg [15:0] x_axis_output,
   output reg sample_strobe,
   output reg fifo_push,
   output reg [7:0] detect_enable,
   output reg activity_armed,
   output reg asleep,
   output reg measuring,
   output reg three_wire_mode,
   output reg self_test_on,
   output reg irq_pin_a,
   output reg irq_pin_b
);
   localparam ST_STANDBY = 3'b001;
   localparam ST_AWAKE = 3'b010;
   localparam ST_SLEEP = 3'b100;
   localparam integer SLEEP_DIV8 = CLK_HZ / `SLEEP_HZ_BASE;

   reg [7:0] interrupt_enable_mask;
   reg [7:0] interrupt_pin_routing;
   reg [7:0] interrupt_event_flags;
   reg [7:0] output_format_control;
   reg [7:0] power_mode_control;
   reg [2:0] state_reg;
   reg [31:0] sleep_cnt_reg;
   reg inact_seen_reg;
   reg aw_hold_reg, w_hold_reg;
   reg [9:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   // Sleep tick period from wakeup field
   function [31:0] sleep_period;
      input [1:0] wake;
      begin
         sleep_period = SLEEP_DIV8 << wake; // [R10]
      end
   endfunction

   // Saturating format of a 13-bit raw sample
   function [15:0] format_sample;
      input [15:0] raw;
      input [7:0] fmt;
      reg signed [15:0] v;
      reg signed [15:0] lim;
      reg [3:0] shift;
      reg [3:0] bits;
      begin
         v = raw;
         shift = 4'd0;
         bits = 4'd10;
         if (!fmt[`FMT_FIXED_SCALE]) begin
            shift = {2'b00, fmt[`FMT_RANGE_HI:`FMT_RANGE_LO]}; // [R20] [R22]
         end else begin
            bits = 4'd10 + {2'b00, fmt[`FMT_RANGE_HI:`FMT_RANGE_LO]}; // [R20]
         end
         v = v >>> shift;
         lim = (16'sd1 <<< (bits - 4'd1)) - 16'sd1;
         if (fmt[`FMT_RANGE_HI:`FMT_RANGE_LO] != 2'b11) begin
            if (v > lim) v = lim; // [R23]
            if (v < -lim - 16'sd1) v = -lim - 16'sd1; // [R23]
         end
         if (fmt[`FMT_JUSTIFY]) begin
            format_sample = v <<< (5'd16 - {1'b0, bits}); // [R21]
         end else begin
            format_sample = v; // [R21]
         end
      end
   endfunction

   wire link_on = power_mode_control[`PWR_LINK];
   wire auto_on = link_on & power_mode_control[`PWR_AUTO_SLEEP]; // [R05]
   wire act_en = interrupt_enable_mask[`EV_ACTIVITY];
   wire inact_en = interrupt_enable_mask[`EV_INACTIVITY];
   wire manual_sleep = power_mode_control[`PWR_SLEEP];
   wire in_sleep = state_reg == ST_SLEEP;
   wire sleep_tick = sleep_cnt_reg >= sleep_period(power_mode_control[1:0]) - 32'd1;
   wire take_sample = in_sleep ? sleep_tick : odr_tick;

   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire aw_ok = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
   wire w_ok = w_hold_reg || (s_axi_wvalid && s_axi_wready);
   wire [9:0] wa = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
   wire [31:0] wd = w_hold_reg ? w_data_reg : s_axi_wdata;
   wire wb0 = w_hold_reg ? w_strb_reg[0] : s_axi_wstrb[0];
   wire do_write = ce && aw_ok && w_ok && !s_axi_bvalid;
   wire do_read = ce && s_axi_arvalid && s_axi_arready;
   wire rd_flags = do_read && s_axi_araddr[9:2] == `ADDR_IRQ_FLAGS >> 2;
   wire rd_data = do_read && s_axi_araddr[9:2] == `ADDR_SAMPLE_X >> 2;
   wire wr_ok_addr = wa[9:2] == `ADDR_IRQ_MASK >> 2 || wa[9:2] == `ADDR_IRQ_ROUTE >> 2
      || wa[9:2] == `ADDR_OUT_FORMAT >> 2 || wa[9:2] == `ADDR_POWER_MODE >> 2;

   // Event set wins over a read clear in the same cycle
   wire [7:0] live_ev = event_pulse
      & ~({8{in_sleep}} & ~(8'h01 << `EV_ACTIVITY)) // [R08]
      & ~({8{!activity_armed}} & (8'h01 << `EV_ACTIVITY)); // [R01]
   wire new_sample_ev = take_sample && state_reg == ST_AWAKE; // [R07]
   wire [7:0] set_ev = live_ev | ({7'h00, new_sample_ev} << `EV_NEW_SAMPLE); // [R16]
   localparam [7:0] DATA_CLR = 8'h83; // [R16]
   wire [7:0] clr_ev = ({8{rd_data}} & DATA_CLR) | ({8{rd_flags}} & ~DATA_CLR); // [R17]

   // Only enabled, routed flags reach a pin
   wire [7:0] pend = interrupt_event_flags & interrupt_enable_mask; // [R11] [R12]
   wire raw_a = |(pend & ~interrupt_pin_routing); // [R14] [R24]
   wire raw_b = |(pend & interrupt_pin_routing); // [R14] [R24]

   always @(posedge clk) begin
      if (!nrst) begin
         interrupt_enable_mask <= `RST_BYTE;
         interrupt_pin_routing <= `RST_BYTE;
         interrupt_event_flags <= `RST_BYTE;
         output_format_control <= `RST_BYTE;
         power_mode_control <= `RST_BYTE; // [R06]
         state_reg <= ST_STANDBY;
         sleep_cnt_reg <= 32'd0;
         inact_seen_reg <= 1'b0;
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 10'h000;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h0000_0000;
         x_axis_output <= 16'h0000;
         sample_strobe <= 1'b0;
         fifo_push <= 1'b0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready && !do_write) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !do_write) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok_addr ? 2'b00 : 2'b10;
            if (wb0) begin
               if (wa[9:2] == `ADDR_IRQ_MASK >> 2) interrupt_enable_mask <= wd[7:0]; // [R13]
               if (wa[9:2] == `ADDR_IRQ_ROUTE >> 2) interrupt_pin_routing <= wd[7:0]; // [R13]
               if (wa[9:2] == `ADDR_OUT_FORMAT >> 2) output_format_control <= wd[7:0] & 8'hef;
               if (wa[9:2] == `ADDR_POWER_MODE >> 2) power_mode_control <= wd[7:0] & 8'h3f;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr[9:2])
               `ADDR_IRQ_MASK >> 2: s_axi_rdata <= {24'h0, interrupt_enable_mask};
               `ADDR_IRQ_ROUTE >> 2: s_axi_rdata <= {24'h0, interrupt_pin_routing};
               `ADDR_IRQ_FLAGS >> 2: s_axi_rdata <= {24'h0, interrupt_event_flags}; // [R15]
               `ADDR_OUT_FORMAT >> 2: s_axi_rdata <= {24'h0, output_format_control};
               `ADDR_POWER_MODE >> 2: s_axi_rdata <= {24'h0, power_mode_control};
               `ADDR_SAMPLE_X >> 2: s_axi_rdata <= {16'h0, x_axis_output};
               `ADDR_STATUS >> 2: s_axi_rdata <= {29'h0, state_reg};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         interrupt_event_flags <= (interrupt_event_flags & ~clr_ev) | set_ev; // [R16] [R17]

         sleep_cnt_reg <= (!in_sleep || sleep_tick) ? 32'd0 : sleep_cnt_reg + 32'd1;
         sample_strobe <= take_sample && state_reg != ST_STANDBY;
         fifo_push <= take_sample && state_reg == ST_AWAKE; // [R07]
         if (take_sample && state_reg != ST_STANDBY) begin
            x_axis_output <= format_sample(raw_sample, output_format_control); // [R09]
         end

         // Link chaining: after inactivity, activity arms; after activity, activity disarms until the next inactivity
         if (!link_on || !(act_en && inact_en)) begin
            inact_seen_reg <= 1'b0;
         end else if (live_ev[`EV_INACTIVITY]) begin
            inact_seen_reg <= 1'b1; // [R01]
         end else if (live_ev[`EV_ACTIVITY]) begin
            inact_seen_reg <= 1'b0;
         end

         case (state_reg)
            ST_STANDBY: begin
               if (power_mode_control[`PWR_MEASURE]) state_reg <= manual_sleep ? ST_SLEEP : ST_AWAKE;
            end
            ST_AWAKE: begin
               if (!power_mode_control[`PWR_MEASURE]) state_reg <= ST_STANDBY; // [R06]
               else if (manual_sleep) state_reg <= ST_SLEEP; // [R07]
               else if (auto_on && inact_en && live_ev[`EV_INACTIVITY]) state_reg <= ST_SLEEP; // [R03]
            end
            ST_SLEEP: begin
               if (!power_mode_control[`PWR_MEASURE]) state_reg <= ST_STANDBY;
               else if (!manual_sleep && !auto_on) state_reg <= ST_AWAKE;
               else if (!manual_sleep && act_en && live_ev[`EV_ACTIVITY]) state_reg <= ST_AWAKE; // [R04]
            end
            default: state_reg <= ST_STANDBY;
         endcase
      end
   end

   always @(posedge clk) begin
      if (!nrst) begin
         irq_pin_a <= 1'b0;
         irq_pin_b <= 1'b0;
         detect_enable <= 8'h00;
         activity_armed <= 1'b1;
         asleep <= 1'b0;
         measuring <= 1'b0;
         three_wire_mode <= 1'b0;
         self_test_on <= 1'b0;
      end else if (ce) begin
         irq_pin_a <= raw_a ^ output_format_control[`FMT_IRQ_INVERT]; // [R19] [R24]
         irq_pin_b <= raw_b ^ output_format_control[`FMT_IRQ_INVERT]; // [R19] [R24]
         // Event functions run regardless of enables except during sleep
         detect_enable <= in_sleep ? (8'h01 << `EV_ACTIVITY) : 8'hff; // [R08] [R12]
         activity_armed <= !(link_on && act_en && inact_en) || inact_seen_reg; // [R01]
         asleep <= in_sleep;
         measuring <= state_reg != ST_STANDBY; // [R06]
         three_wire_mode <= output_format_control[`FMT_THREE_WIRE]; // [R18]
         self_test_on <= output_format_control[`FMT_SELF_TEST];
      end
   end
endmodule

// File: logic/accel_ctrl_regs.vh
`ifndef ACCEL_CTRL_REGS_VH
`define ACCEL_CTRL_REGS_VH

// Register indices; each register sits in one word, byte address is index * 4
`define IDX_IRQ_MASK 8'h2e
`define IDX_IRQ_ROUTE 8'h2f
`define IDX_IRQ_FLAGS 8'h30
`define IDX_OUT_FORMAT 8'h31
`define IDX_POWER_MODE 8'h2d
`define IDX_SAMPLE_X 8'h32
`define ADDR_IRQ_MASK 10'h0b8
`define ADDR_IRQ_ROUTE 10'h0bc
`define ADDR_IRQ_FLAGS 10'h0c0
`define ADDR_OUT_FORMAT 10'h0c4
`define ADDR_POWER_MODE 10'h0b4
`define ADDR_SAMPLE_X 10'h0c8
`define ADDR_STATUS 10'h0cc

// Event bit positions, shared by enable, routing and flag registers
`define EV_NEW_SAMPLE 7
`define EV_SINGLE_TAP 6
`define EV_DOUBLE_TAP 5
`define EV_ACTIVITY 4
`define EV_INACTIVITY 3
`define EV_FREE_FALL 2
`define EV_WATERMARK 1
`define EV_OVERRUN 0

// Power control fields
`define PWR_LINK 5
`define PWR_AUTO_SLEEP 4
`define PWR_MEASURE 3
`define PWR_SLEEP 2
`define PWR_WAKE_HI 1
`define PWR_WAKE_LO 0

// Format control fields
`define FMT_SELF_TEST 7
`define FMT_THREE_WIRE 6
`define FMT_IRQ_INVERT 5
`define FMT_FIXED_SCALE 3
`define FMT_JUSTIFY 2
`define FMT_RANGE_HI 1
`define FMT_RANGE_LO 0

`define RST_BYTE 8'h00

// Clock and sleep sampling rates
`define CLK_HZ 20000000
`define SLEEP_HZ_BASE 8

`endif

// File: sim/accel_ctrl_props.sv
`timescale 1ns/1ps
module accel_ctrl_props (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire fifo_push,
   input wire [7:0] detect_enable,
   input wire asleep,
   input wire measuring,
   input wire irq_pin_a
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   reset_standby_a: assert property (!$past(nrst) |-> !(measuring || asleep || irq_pin_a))
      else $error("not idle after reset");
   // Two sleeping samples so the registered push reflects sleep
   sleep_no_push_a: assert property (asleep && $past(asleep) |-> !fifo_push)
      else $error("push while asleep");
   sleep_only_act_a: assert property (asleep && $past(asleep) |-> !(detect_enable & 8'hef))
      else $error("detector other than activity runs in sleep");
   write_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid) else $error("no write response");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   read_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data not held");
   write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
endmodule
bind accel_ctrl accel_ctrl_props accel_ctrl_props_inst (.clk(clk), .nrst(nrst), .ce(ce),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .fifo_push(fifo_push), .detect_enable(detect_enable), .asleep(asleep),
   .measuring(measuring), .irq_pin_a(irq_pin_a));

// File: sim/sensor_stub.sv
`timescale 1ns/1ps
module sensor_stub (
   input wire clk,
   input wire [7:0] fire,
   input wire tick,
   input wire [15:0] value,
   output reg [7:0] event_pulse,
   output reg odr_tick,
   output reg [15:0] raw_sample
);
   // Detectors answer one edge late, as single-cycle pulses
   always @(posedge clk) begin
      event_pulse <= fire;
      odr_tick <= tick;
      raw_sample <= value;
   end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
`include "accel_ctrl_regs.vh"
module tb;
   reg clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   reg arvalid = 1'b0, rready = 1'b0, tick = 1'b0, run = 1'b1, hs;
   reg [9:0] awaddr = 10'h000, araddr = 10'h000;
   reg [31:0] wdata = 32'h00000000, rd;
   reg [7:0] fire = 8'h00;
   reg [15:0] value = 16'h0000;
   reg [1:0] rr;
   wire awready, wready, bvalid, arready, rvalid, strobe, push, armed, asleep, measuring;
   wire three_wire, pa, pb, ev_tick;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] x_out, raw;
   wire [7:0] det, ev;
   integer err_total = 0, comparisons = 0, pushes = 0, strobes = 0, i, n, p;
   sensor_stub sensor_stub_inst (.clk(clk), .fire(fire), .tick(tick), .value(value),
      .event_pulse(ev), .odr_tick(ev_tick), .raw_sample(raw));
   accel_ctrl #(.CLK_HZ(64)) accel_ctrl_inst (.clk(clk), .nrst(nrst), .ce(run),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .event_pulse(ev), .raw_sample(raw), .odr_tick(ev_tick), .x_axis_output(x_out),
      .sample_strobe(strobe), .fifo_push(push), .detect_enable(det), .activity_armed(armed),
      .asleep(asleep), .measuring(measuring), .three_wire_mode(three_wire),
      .self_test_on(), .irq_pin_a(pa), .irq_pin_b(pb));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      pushes <= pushes + push;
      strobes <= strobes + strobe;
   end
   task check(input [31:0] e, input [31:0] g, input [8*10:1] w);
      comparisons = comparisons + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("wrong value %0s expected %h seen %h", w, e, g);
      end
   endtask
   // One access, write or read; every handshake is judged at the rising edge
   task acc(input w, input [9:0] a, input [7:0] d);
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      bready <= w;
      rready <= !w;
      hs = 1'b0;
      while (!hs) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
         hs = w ? bvalid : rvalid;
         rd = rdata;
         rr = w ? bresp : rresp;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task rchk(input [9:0] a, input [7:0] e);
      acc(1'b0, a, 8'h00);
      check({24'h000000, e}, rd, "rdata");
      check(2'b00, rr, "resp");
   endtask
   task fire_ev(input [7:0] e, input t);
      @(posedge clk);
      fire <= e;
      tick <= t;
      @(posedge clk);
      fire <= 8'h00;
      tick <= 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task fmt(input [7:0] f, input [15:0] v, input [15:0] e);
      acc(1'b1, `ADDR_OUT_FORMAT, f);
      value <= v;
      fire_ev(8'h00, 1'b1);
      check(e, x_out, "x data");
   endtask
   task end_of_test;
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #3000000;
      err_total = err_total + 1;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (i = 0; i < 5; i = i + 1)
         rchk(10'h0b4 + 4 * i, 8'h00);
      rchk(`ADDR_STATUS, 8'h01);
      acc(1'b0, 10'h3f0, 8'h00);
      check(2'b10, rr, "resp");
      check(0, rd, "rdata");
      acc(1'b1, 10'h3f0, 8'h00);
      check(2'b10, rr, "resp");
      acc(1'b1, `ADDR_POWER_MODE, 8'h08);
      check(2'b00, rr, "resp");
      rchk(`ADDR_STATUS, 8'h02);
      // Clock enable low must freeze the flags
      @(posedge clk);
      run <= 1'b0;
      fire_ev(8'h04, 1'b0);
      @(posedge clk);
      run <= 1'b1;
      rchk(`ADDR_IRQ_FLAGS, 8'h00);
      for (i = 0; i < 7; i = i + 1) begin
         acc(1'b1, `ADDR_IRQ_MASK, 8'h01 << i);
         fire_ev(8'h01 << i, 1'b0);
         check(1, pa, "pin a");
         check(0, pb, "pin b");
         rchk(`ADDR_IRQ_FLAGS, 8'h01 << i);
         check(i < 2, pa, "pin a");
         acc(1'b0, `ADDR_SAMPLE_X, 8'h00);
         check(0, pa, "pin a");
      end
      acc(1'b1, `ADDR_IRQ_ROUTE, 8'h40);
      acc(1'b1, `ADDR_IRQ_MASK, 8'h40);
      fire_ev(8'h40, 1'b0);
      check(0, pa, "pin a");
      check(1, pb, "pin b");
      acc(1'b1, `ADDR_IRQ_MASK, 8'h00);
      acc(1'b0, `ADDR_IRQ_FLAGS, 8'h00);
      fire_ev(8'h40, 1'b0);
      check(0, pb, "pin b");
      rchk(`ADDR_IRQ_FLAGS, 8'h40);
      acc(1'b1, `ADDR_OUT_FORMAT, 8'h60);
      check(1, pb, "pin b");
      check(1, three_wire, "three wire");
      for (i = 0; i < 4; i = i + 1)
         fmt(i, 16'h0040, 16'h0040 >> i);
      fmt(8'h00, 16'h0fff, 16'h01ff);
      fmt(8'h01, 16'hf000, 16'hfe00);
      fmt(8'h0b, 16'h0fff, 16'h0fff);
      fmt(8'h04, 16'h0fff, 16'h7fc0);
      @(posedge clk);
      value <= 16'h0010;
      p = pushes;
      for (i = 0; i < 4; i = i + 1) begin
         acc(1'b1, `ADDR_POWER_MODE, 8'h0c | i);
         n = strobes;
         repeat (128) @(negedge clk);
         check(1, asleep, "asleep");
         check(0, det & 8'hef, "detect");
         check(1, strobes - n >= (16 >> i) - 1 && strobes - n <= (16 >> i) + 1, "rate");
      end
      check(16'h0400, x_out, "x data");
      fire_ev(8'h00, 1'b1);
      check(p, pushes, "pushes");
      acc(1'b1, `ADDR_POWER_MODE, 8'h00);
      acc(1'b1, `ADDR_IRQ_MASK, 8'h18);
      acc(1'b1, `ADDR_POWER_MODE, 8'h18);
      fire_ev(8'h08, 1'b0);
      check(0, asleep, "asleep");
      acc(1'b1, `ADDR_POWER_MODE, 8'h38);
      check(0, armed, "armed");
      fire_ev(8'h08, 1'b0);
      check(1, asleep, "asleep");
      check(1, armed, "armed");
      fire_ev(8'h10, 1'b0);
      check(0, asleep, "asleep");
      end_of_test;
   end
endmodule
